// ---- pkg/smcs_pkg.sv ----
// Shared constants and carrier types for the shunt monitor conversion sequencer.
// Assumes a single 10 MHz system clock and a 16-bit register port.
package smcs_pkg;

	// Register port addresses.
	localparam logic [7:0] REG_CONFIG  = 8'h00;
	localparam logic [7:0] REG_SHUNT   = 8'h01;
	localparam logic [7:0] REG_BUS     = 8'h02;
	localparam logic [7:0] REG_POWER   = 8'h03;
	localparam logic [7:0] REG_CURRENT = 8'h04;
	localparam logic [7:0] REG_CAL     = 8'h05;
	localparam logic [7:0] REG_MASK    = 8'h06;
	localparam logic [7:0] REG_STATUS  = 8'h07;

	// Configuration register field positions.
	localparam int MODE_LSB     = 0;
	localparam int SHUNT_CT_LSB = 3;
	localparam int BUS_CT_LSB   = 6;
	localparam int AVG_LSB      = 9;

	// Mask register: position of the conversion ready flag.
	localparam int MASK_READY_BIT = 3;

	// Status register bit positions.
	localparam int STAT_READY_BIT   = 0;
	localparam int STAT_BUSY_BIT    = 1;
	localparam int STAT_RECOVER_BIT = 2;
	localparam int STAT_PDOWN_BIT   = 3;

	// Reset values: continuous shunt and bus, 1.1 ms each, one average.
	localparam logic [15:0] CONFIG_RESET = 16'h0127;
	localparam logic [15:0] CAL_RESET    = 16'h0000;
	localparam logic [15:0] MASK_RESET   = 16'h0000;

	// Timing in microseconds, and the system clock rate.
	localparam int CLK_MHZ      = 10;
	localparam int RECOVER_US   = 40000;
	localparam int TIMEOUT_US   = 28000;
	localparam logic [13:0] CT_US [8] = '{14'd140, 14'd204, 14'd332, 14'd588,
		14'd1100, 14'd2116, 14'd4156, 14'd8244};

	// Averaging codes as a power of two of the sample count.
	localparam logic [3:0] AVG_LOG2 [8] = '{4'd0, 4'd2, 4'd4, 4'd6,
		4'd7, 4'd8, 4'd9, 4'd10};

	// Scaling of the current and power products.
	localparam int CUR_SHIFT = 11;
	localparam int PWR_SHIFT = 15;

	// Serial target address base above the two strap fields.
	localparam logic [2:0] ADDR_BASE = 3'h4;

	// One register port request.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} smcs_req_type;

	// One pair of raw converter samples.
	typedef struct packed {
		logic [15:0] shunt;
		logic [15:0] bus;
	} smcs_sample_type;

	// Published averaged results.
	typedef struct packed {
		logic [15:0] shunt;
		logic [15:0] bus;
		logic [15:0] current;
		logic [15:0] power;
	} smcs_results_type;

endpackage

// ---- design/smcs_sequencer.sv ----
// Conversion sequencer of a current and power monitor: mode control, timing,
// averaging, result publication and ready flag, plus serial address and timeout.
// Assumes the converter front end presents valid samples at the end of each
// conversion window, and that all inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module smcs_sequencer #(
	parameter int TICK_DIV    = smcs_pkg::CLK_MHZ,
	parameter int RECOVER_TKS = smcs_pkg::RECOVER_US,
	parameter int TIMEOUT_TKS = smcs_pkg::TIMEOUT_US,
	parameter int ACC_W       = 32
) (
	// Clock and reset.
	input  wire logic                       sys_clk,
	input  wire logic                       rst,
	// Register port.
	input  wire smcs_pkg::smcs_req_type     bus_req,
	output logic [15:0]                     rd_data,
	// Converter front end.
	input  wire smcs_pkg::smcs_sample_type  adc_sample,
	output logic                            shunt_convert,
	output logic                            bus_convert,
	output logic                            input_isolate,
	output logic                            power_down,
	// Published results and status.
	output var smcs_pkg::smcs_results_type  results,
	output logic                            conversion_ready_flag,
	output logic                            recovering,
	// Serial interface support.
	input  wire logic [1:0]                 addr_select_low,
	input  wire logic [1:0]                 addr_select_high,
	input  wire logic                       scl_in,
	output logic [6:0]                      target_addr,
	output logic                            serial_reset
);
	import smcs_pkg::*;

	// Refuse settings the counters cannot hold.
	if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_div
		$error("TICK_DIV out of range");
	end
	if (RECOVER_TKS < 1 || RECOVER_TKS > 65535) begin : g_bad_rec
		$error("RECOVER_TKS out of range");
	end
	if (TIMEOUT_TKS < 1 || TIMEOUT_TKS > 65535) begin : g_bad_tmo
		$error("TIMEOUT_TKS out of range");
	end
	if (ACC_W < 27 || ACC_W > 48) begin : g_bad_acc
		$error("ACC_W must hold 1024 sixteen-bit samples");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_SHUNT, ST_BUS} smcs_state_type;

	// Nonzero low mode bits mean an active mode; both zero means power-down.
	function automatic logic mode_active(input logic [2:0] m);
		return m[1:0] != 2'b00;
	endfunction

	// First phase of a set: shunt when selected, otherwise bus.
	function automatic smcs_state_type first_phase(input logic [2:0] m);
		return m[0] ? ST_SHUNT : ST_BUS;
	endfunction

	// Averaged value of an accumulated sum, cut to the register width.
	function automatic logic [15:0] avg_of(input logic signed [ACC_W-1:0] s, input logic [3:0] sh);
		logic signed [ACC_W-1:0] q;
		q = s >>> sh;
		return q[15:0];
	endfunction

	// Registers.
	logic [15:0]             config_q;
	logic [15:0]             cal_q;
	logic [15:0]             mask_q;
	logic                    flag_q;
	smcs_results_type        results_q;
	smcs_state_type          state_q;
	logic [15:0]             tick_cnt_q;
	logic [13:0]             conv_cnt_q;
	logic [10:0]             samp_cnt_q;
	logic signed [ACC_W-1:0] acc_shunt_q;
	logic signed [ACC_W-1:0] acc_bus_q;
	logic signed [ACC_W-1:0] acc_cur_q;
	logic signed [ACC_W-1:0] acc_pwr_q;
	logic [15:0]             last_bus_q;
	logic [15:0]             last_shunt_q;
	logic [15:0]             cur_q;
	logic [15:0]             rec_cnt_q;
	logic [15:0]             scl_cnt_q;
	logic                    scl_fired_q;
	logic                    serial_reset_q;
	logic [6:0]              target_addr_q;
	logic                    strap_done_q;
	logic [15:0]             rd_data_q;

	// Request decode.
	wire         wr_cfg    = bus_req.wr && bus_req.addr == REG_CONFIG;
	wire         wr_cal    = bus_req.wr && bus_req.addr == REG_CAL;
	wire         wr_mask   = bus_req.wr && bus_req.addr == REG_MASK;
	wire         rd_status = bus_req.rd && bus_req.addr == REG_STATUS;
	wire [2:0]   mode      = config_q[MODE_LSB +: 3];
	wire [2:0]   new_mode  = bus_req.wdata[MODE_LSB +: 3];
	wire [2:0]   shunt_ct  = config_q[SHUNT_CT_LSB +: 3];
	wire [2:0]   bus_ct    = config_q[BUS_CT_LSB +: 3];
	wire [3:0]   avg_log2  = AVG_LOG2[config_q[AVG_LSB +: 3]];
	wire [10:0]  avg_count = 11'(11'h001 << avg_log2);

	// Slow time base: one pulse per microsecond at the default divider.
	wire tick = tick_cnt_q == 16'(TICK_DIV - 1);

	// Conversion window end for the phase in progress.
	wire [13:0] ct_limit  = CT_US[(state_q == ST_SHUNT) ? shunt_ct : bus_ct];
	wire        conv_end  = tick && state_q != ST_IDLE && conv_cnt_q == ct_limit - 14'h0001;
	wire        shunt_end = conv_end && state_q == ST_SHUNT;
	wire        bus_end   = conv_end && state_q == ST_BUS;
	// A set ends after bus, or after shunt when bus is not selected.
	wire        set_end   = bus_end || (shunt_end && !mode[1]);
	wire        last_samp = set_end && (samp_cnt_q + 11'h001 == avg_count);

	// Current and power are combinational on the sample edge, so the products
	// are ready in the cycle the window closes and add no conversion time.
	wire signed [32:0] cur_prod = $signed(adc_sample.shunt) * $signed({1'b0, cal_q});
	wire signed [32:0] cur_shft = cur_prod >>> CUR_SHIFT;
	wire [15:0]        cur_new  = (cal_q == 16'h0000) ? 16'h0000 : cur_shft[15:0];
	wire [15:0]        cur_use  = shunt_end ? cur_new : cur_q;
	wire [15:0]        bus_use  = bus_end ? adc_sample.bus : last_bus_q;
	wire signed [32:0] pwr_prod = $signed(cur_use) * $signed({1'b0, bus_use});
	wire signed [32:0] pwr_shft = pwr_prod >>> PWR_SHIFT;
	wire [15:0]        pwr_new  = (cal_q == 16'h0000) ? 16'h0000 : pwr_shft[15:0];

	// Sums including the set that closes this cycle. In a two-channel set the
	// accumulators load on the bus edge, when the shunt lines no longer carry the
	// sample, so the shunt value comes from the copy taken when its window closed.
	wire [15:0]              shunt_now = shunt_end ? adc_sample.shunt : last_shunt_q;
	wire [15:0]              shunt_use = mode[0] ? shunt_now : 16'h0000;
	wire signed [ACC_W-1:0]  sum_shunt = acc_shunt_q + ACC_W'($signed(shunt_use));
	wire signed [ACC_W-1:0]  sum_bus   = acc_bus_q + ACC_W'({1'b0, bus_use});
	wire signed [ACC_W-1:0]  sum_cur   = acc_cur_q + ACC_W'($signed(cur_use));
	wire signed [ACC_W-1:0]  sum_pwr   = acc_pwr_q + ACC_W'({1'b0, pwr_new});

	// Ready flag: a set on completion beats a clear in the same cycle.
	wire flag_clr = (wr_cfg && mode_active(new_mode)) || rd_status;
	wire flag_d   = last_samp || (flag_q && !flag_clr);

	// Recovery starts when an active mode replaces power-down.
	wire leave_pd = wr_cfg && mode_active(new_mode) && !mode_active(mode);

	// Read multiplexer; result reads are pure and touch no sequence state.
	// Unmapped addresses read as zero, so probing an empty slot is harmless.
	wire [15:0] status_word = 16'(
		({15'h0000, flag_q} << STAT_READY_BIT) |
		({15'h0000, state_q != ST_IDLE} << STAT_BUSY_BIT) |
		({15'h0000, rec_cnt_q != 16'h0000} << STAT_RECOVER_BIT) |
		({15'h0000, !mode_active(mode)} << STAT_PDOWN_BIT));
	logic [15:0] rd_next;
	always_comb begin
		unique case (bus_req.addr)
			REG_CONFIG:  rd_next = config_q;
			REG_SHUNT:   rd_next = results_q.shunt;
			REG_BUS:     rd_next = results_q.bus;
			REG_POWER:   rd_next = results_q.power;
			REG_CURRENT: rd_next = results_q.current;
			REG_CAL:     rd_next = cal_q;
			REG_MASK:    rd_next = mask_q | 16'({15'h0000, flag_q} << MASK_READY_BIT);
			REG_STATUS:  rd_next = status_word;
			default:     rd_next = 16'h0000;
		endcase
	end

	// Host-writable registers stay writable in every mode.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			config_q <= CONFIG_RESET;
			cal_q    <= CAL_RESET;
			mask_q   <= MASK_RESET;
		end else begin
			if (wr_cfg)
				config_q <= bus_req.wdata;
			if (wr_cal)
				cal_q <= bus_req.wdata;
			if (wr_mask)
				mask_q <= bus_req.wdata & ~16'(16'h0001 << MASK_READY_BIT);
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge sys_clk) begin
		if (rst)
			rd_data_q <= 16'h0000;
		else
			rd_data_q <= bus_req.rd ? rd_next : 16'h0000;
	end

	// Microsecond divider.
	// A divider of one makes every cycle a tick, which keeps simulation short.
	always_ff @(posedge sys_clk) begin
		if (rst || tick)
			tick_cnt_q <= 16'h0000;
		else
			tick_cnt_q <= tick_cnt_q + 16'h0001;
	end

	// Sequence control. A configuration write aborts any set in progress and
	// restarts from scratch, so a rewrite of the same triggered mode fires again.
	// A write that lands on the very edge a set completes still lets that set
	// publish and raise the flag; the new configuration then starts afresh.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q    <= ST_SHUNT;
			conv_cnt_q <= 14'h0000;
			samp_cnt_q <= 11'h000;
		end else if (wr_cfg) begin
			state_q    <= mode_active(new_mode) ? first_phase(new_mode) : ST_IDLE;
			conv_cnt_q <= 14'h0000;
			samp_cnt_q <= 11'h000;
		end else if (conv_end) begin
			conv_cnt_q <= 14'h0000;
			if (shunt_end && mode[1])
				state_q <= ST_BUS;
			else if (last_samp)
				state_q <= mode[2] ? first_phase(mode) : ST_IDLE;
			else
				state_q <= first_phase(mode);
			if (set_end)
				samp_cnt_q <= last_samp ? 11'h000 : samp_cnt_q + 11'h001;
		end else if (tick && state_q != ST_IDLE) begin
			conv_cnt_q <= conv_cnt_q + 14'h0001;
		end
	end

	// Accumulators restart with each configuration write and after publication.
	// Their width must hold 1024 full-scale samples plus sign; see the check above.
	always_ff @(posedge sys_clk) begin
		if (rst || wr_cfg || last_samp) begin
			acc_shunt_q <= '0;
			acc_bus_q   <= '0;
			acc_cur_q   <= '0;
			acc_pwr_q   <= '0;
		end else if (set_end) begin
			acc_shunt_q <= sum_shunt;
			acc_bus_q   <= sum_bus;
			acc_cur_q   <= sum_cur;
			acc_pwr_q   <= sum_pwr;
		end
	end

	// Latest shunt, current and bus. The shunt copy feeds the accumulator at the
	// end of the bus window; current and bus let a single-channel mode form power.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur_q        <= 16'h0000;
			last_bus_q   <= 16'h0000;
			last_shunt_q <= 16'h0000;
		end else begin
			if (shunt_end) begin
				cur_q        <= cur_new;
				last_shunt_q <= adc_sample.shunt;
			end
			if (bus_end)
				last_bus_q <= adc_sample.bus;
		end
	end

	// Results change only when a whole averaged set is done.
	// Averaging by shift rounds negative shunt sums toward minus infinity.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			results_q <= '0;
		end else if (last_samp) begin
			results_q.shunt   <= avg_of(sum_shunt, avg_log2);
			results_q.bus     <= avg_of(sum_bus, avg_log2);
			results_q.current <= avg_of(sum_cur, avg_log2);
			results_q.power   <= avg_of(sum_pwr, avg_log2);
		end
	end

	// Conversion ready flag.
	always_ff @(posedge sys_clk) begin
		if (rst)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

	// Recovery timer after power-down; conversions run but are flagged unsettled.
	// Nothing withholds results here, so the host must ignore them while it runs.
	always_ff @(posedge sys_clk) begin
		if (rst)
			rec_cnt_q <= 16'h0000;
		else if (leave_pd)
			rec_cnt_q <= 16'(RECOVER_TKS);
		else if (wr_cfg && !mode_active(new_mode))
			rec_cnt_q <= 16'h0000;
		else if (tick && rec_cnt_q != 16'h0000)
			rec_cnt_q <= rec_cnt_q - 16'h0001;
	end

	// Clock-line low timeout: one reset pulse per over-long low period.
	// A line stuck low gives a single pulse, so the interface is not reset over and over.
	always_ff @(posedge sys_clk) begin
		if (rst || scl_in) begin
			scl_cnt_q      <= 16'h0000;
			scl_fired_q    <= 1'b0;
			serial_reset_q <= 1'b0;
		end else begin
			serial_reset_q <= 1'b0;
			if (tick && !scl_fired_q) begin
				if (scl_cnt_q == 16'(TIMEOUT_TKS - 1)) begin
					scl_fired_q    <= 1'b1;
					serial_reset_q <= 1'b1;
				end else begin
					scl_cnt_q <= scl_cnt_q + 16'h0001;
				end
			end
		end
	end

	// Straps are caught once after reset; they are pins, not live controls.
	// A strap moved later takes effect only after the next reset.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			strap_done_q  <= 1'b0;
			target_addr_q <= 7'h00;
		end else if (!strap_done_q) begin
			strap_done_q  <= 1'b1;
			target_addr_q <= {ADDR_BASE, addr_select_high, addr_select_low};
		end
	end

	// Outputs.
	assign rd_data               = rd_data_q;
	assign results               = results_q;
	assign conversion_ready_flag = flag_q;
	assign shunt_convert         = state_q == ST_SHUNT;
	assign bus_convert           = state_q == ST_BUS;
	assign power_down            = !mode_active(mode);
	assign input_isolate         = !mode_active(mode);
	assign recovering            = rec_cnt_q != 16'h0000;
	assign target_addr           = target_addr_q;
	assign serial_reset          = serial_reset_q;

endmodule

`default_nettype wire

// ---- verification/smcs_sequencer_chk.sv ----
// Checker for the conversion sequencer, watching only its top-level ports.
// Assumes one clock domain, synchronous active-high reset, and a bench
// that never writes configuration on the very edge a result set completes.
`timescale 1ns/1ps
`default_nettype none

module smcs_sequencer_chk
	import smcs_pkg::*;
(
	// Clock and reset.
	input wire logic                        sys_clk,
	input wire logic                        rst,
	// Register port.
	input wire smcs_pkg::smcs_req_type      bus_req,
	input wire logic [15:0]                 rd_data,
	// Converter control.
	input wire logic                        shunt_convert,
	input wire logic                        bus_convert,
	input wire logic                        input_isolate,
	input wire logic                        power_down,
	// Results and status.
	input wire smcs_pkg::smcs_results_type  results,
	input wire logic                        conversion_ready_flag,
	input wire logic                        recovering,
	// Serial support.
	input wire logic [1:0]                  addr_select_low,
	input wire logic [1:0]                  addr_select_high,
	input wire logic                        scl_in,
	input wire logic [6:0]                  target_addr,
	input wire logic                        serial_reset
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Configuration write decode, split by whether the mode is active.
	logic cfg_wr;
	logic cfg_act;
	assign cfg_wr  = bus_req.wr && bus_req.addr == REG_CONFIG;
	assign cfg_act = cfg_wr && bus_req.wdata[1:0] != 2'b00;

	property p_rd_idle; !$past(bus_req.rd) |-> rd_data == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_flag_cfg; cfg_act |=> !conversion_ready_flag; endproperty
	a_flag_cfg: assert property (p_flag_cfg) else $error("flag kept on write");
	property p_flag_pd;
		cfg_wr && !cfg_act && conversion_ready_flag |=> conversion_ready_flag;
	endproperty
	a_flag_pd: assert property (p_flag_pd) else $error("flag lost on power-down");
	property p_status;
		bus_req.rd && bus_req.addr == REG_STATUS |=>
			rd_data[STAT_READY_BIT] == $past(conversion_ready_flag) && !conversion_ready_flag;
	endproperty
	a_status: assert property (p_status) else $error("status read wrong");
	property p_publish; results != $past(results) |-> conversion_ready_flag; endproperty
	a_publish: assert property (p_publish) else $error("results changed early");
	property p_iso;
		cfg_wr |=> power_down == !$past(cfg_act) && input_isolate == power_down;
	endproperty
	a_iso: assert property (p_iso) else $error("inputs not isolated");
	property p_pd_idle; power_down |-> !shunt_convert && !bus_convert; endproperty
	a_pd_idle: assert property (p_pd_idle) else $error("converting in power-down");
	property p_excl; !(shunt_convert && bus_convert); endproperty
	a_excl: assert property (p_excl) else $error("two windows at once");
	property p_recover; $fell(power_down) |-> ##[0:1] recovering; endproperty
	a_recover: assert property (p_recover) else $error("no recovery flag");
	property p_addr;
		!$past(rst) |-> target_addr == {ADDR_BASE, addr_select_high, addr_select_low};
	endproperty
	a_addr: assert property (p_addr) else $error("target address wrong");
	property p_sreset;
		serial_reset |-> !$past(scl_in) && !$past(scl_in, 8) && !$past(serial_reset);
	endproperty
	a_sreset: assert property (p_sreset) else $error("serial reset unexpected");

	// Main scenarios reached.
	c_ready: cover property ($rose(conversion_ready_flag));
	c_pdown: cover property ($rose(power_down));
	c_sreset: cover property (serial_reset);
endmodule

bind smcs_sequencer smcs_sequencer_chk i_smcs_sequencer_chk (.sys_clk, .rst, .bus_req,
	.rd_data, .shunt_convert, .bus_convert, .input_isolate, .power_down, .results,
	.conversion_ready_flag, .recovering, .addr_select_low, .addr_select_high, .scl_in,
	.target_addr, .serial_reset);

`default_nettype wire

// ---- verification/smcs_adc_model.sv ----
// Behavioural converter front end facing the sequencer.
// Assumes samples are wanted only inside conversion windows.
`timescale 1ns/1ps
`default_nettype none

module smcs_adc_model #(
	parameter logic [15:0] SHUNT_VAL = 16'h0400,
	parameter logic [15:0] BUS_VAL   = 16'h2000
) (
	// Clock and window controls.
	input wire logic                       sys_clk,
	input wire logic                       shunt_convert,
	input wire logic                       bus_convert,
	input wire logic                       input_isolate,
	// Samples.
	output var smcs_pkg::smcs_sample_type  adc_sample
);
	logic [15:0] junk_q = 16'h5A5A;

	// Outside a window the lines churn, so a sample taken at the wrong time shows.
	always_ff @(posedge sys_clk) begin
		junk_q <= junk_q + 16'h3C5B;
	end

	// An isolated front end gives nothing meaningful.
	always_comb begin
		adc_sample.shunt = (shunt_convert && !input_isolate) ? SHUNT_VAL : junk_q;
		adc_sample.bus   = (bus_convert && !input_isolate) ? BUS_VAL : ~junk_q;
	end
endmodule

`default_nettype wire

// ---- verification/tb_shunt_monitor_conversion_sequencer.sv ----
// Self-checking bench for the conversion sequencer with a converter model.
// Assumes short simulation parameters: one cycle per tick, short recovery and timeout.
`timescale 1ns/1ps
`default_nettype none

module tb_shunt_monitor_conversion_sequencer;
	import smcs_pkg::*;
	localparam logic [15:0] SH = 16'h0400;
	localparam logic [15:0] BV = 16'h2000;
	logic             sys_clk = 1'b0;
	logic             rst = 1'b1;
	logic             scl_in = 1'b1;
	logic [1:0]       a_lo = 2'd2;
	logic [1:0]       a_hi = 2'd1;
	smcs_req_type     bus_req = '0;
	smcs_sample_type  adc_sample;
	smcs_results_type results;
	logic [15:0]      rd_data;
	logic [6:0]       target_addr;
	logic             shunt_convert, bus_convert, input_isolate, power_down;
	logic             conversion_ready_flag, recovering, serial_reset;
	int               fail_count = 0;
	int               n_checks = 0;
	int               cyc = 0;
	int               t0;
	int               n;
	logic [15:0]      rv;

	smcs_sequencer #(.TICK_DIV(1), .RECOVER_TKS(20), .TIMEOUT_TKS(30)) i_smcs_sequencer (
		.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
		.adc_sample(adc_sample), .shunt_convert(shunt_convert), .bus_convert(bus_convert),
		.input_isolate(input_isolate), .power_down(power_down), .results(results),
		.conversion_ready_flag(conversion_ready_flag), .recovering(recovering),
		.addr_select_low(a_lo), .addr_select_high(a_hi), .scl_in(scl_in),
		.target_addr(target_addr), .serial_reset(serial_reset));
	smcs_adc_model #(.SHUNT_VAL(SH), .BUS_VAL(BV)) i_smcs_adc_model (.sys_clk(sys_clk),
		.shunt_convert(shunt_convert), .bus_convert(bus_convert),
		.input_isolate(input_isolate), .adc_sample(adc_sample));

	always #50 sys_clk = ~sys_clk;

	task automatic give_verdict();
		if (fail_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// A hang is cut short well after the longest expected run.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask

	// One-cycle write strobe; the edge that takes it has landed on return.
	task automatic wr(logic [7:0] a, logic [15:0] d);
		@(posedge sys_clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rd(logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		d = rd_data;
	endtask

	task automatic wait_flag(int lim);
		n = 0;
		while (conversion_ready_flag !== 1'b1 && n < lim) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("ready in time", 1, n < lim);
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("target address", 7'h46, target_addr);
		rd(REG_CONFIG, rv);
		chk("config reset", CONFIG_RESET, rv);
		rd(REG_CAL, rv);
		chk("cal reset", CAL_RESET, rv);
		rd(8'h1F, rv);
		chk("unmapped read", 16'h0000, rv);
		wait_flag(2500);
		chk("shunt", SH, results.shunt);
		chk("bus", BV, results.bus);
		chk("current no cal", 16'h0000, results.current);
		chk("power no cal", 16'h0000, results.power);
		rd(REG_MASK, rv);
		chk("mask ready bit", 16'h0008, rv);
		// Single shot of both; a read mid-set must not disturb it.
		wr(REG_CAL, 16'h0800);
		wr(REG_CONFIG, 16'h0003);
		t0 = cyc;
		chk("flag after write", 0, conversion_ready_flag);
		repeat (200) @(posedge sys_clk);
		rd(REG_CURRENT, rv);
		chk("current mid set", 16'h0000, rv);
		wait_flag(400);
		chk("set length", 1, (cyc - t0) >= 280 && (cyc - t0) <= 284);
		chk("current", 16'h0400, results.current);
		chk("power", 16'h0100, results.power);
		repeat (300) @(posedge sys_clk);
		chk("stopped", 0, shunt_convert | bus_convert);
		rd(REG_CURRENT, rv);
		chk("held current", 16'h0400, rv);
		rd(REG_STATUS, rv);
		chk("status ready", 1, rv[STAT_READY_BIT]);
		chk("flag after status", 0, conversion_ready_flag);
		wr(REG_CONFIG, 16'h0003);
		@(posedge sys_clk);
		#1;
		chk("retrigger", 1, shunt_convert);
		wait_flag(400);
		// Power-down keeps the flag and the register port alive.
		wr(REG_CONFIG, 16'h0000);
		chk("flag kept", 1, conversion_ready_flag);
		chk("power down", 2'b11, {power_down, input_isolate});
		wr(REG_CAL, 16'h1000);
		rd(REG_CAL, rv);
		chk("cal in power-down", 16'h1000, rv);
		repeat (400) @(posedge sys_clk);
		chk("idle in power-down", 0, shunt_convert | bus_convert);
		wr(REG_CONFIG, 16'h0002);
		chk("recovering", 2'b01, {power_down, recovering});
		wait_flag(400);
		chk("bus only shunt", 16'h0000, results.shunt);
		chk("bus only bus", BV, results.bus);
		wr(REG_CONFIG, 16'h0001);
		wait_flag(400);
		chk("shunt only shunt", SH, results.shunt);
		chk("shunt only current", 16'h0800, results.current);
		// Four averages: nothing published before the fourth set.
		wr(REG_CONFIG, 16'h0207);
		repeat (840) @(posedge sys_clk);
		#1;
		chk("flag before count", 0, conversion_ready_flag);
		wait_flag(600);
		chk("averaged shunt", SH, results.shunt);
		// Held-low serial clock resets the serial logic.
		@(posedge sys_clk);
		scl_in <= 1'b0;
		n = 0;
		while (serial_reset !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("serial reset", 1, serial_reset);
		scl_in <= 1'b1;
		give_verdict();
	end
endmodule

`default_nettype wire
